// ### rtl/hw_strap_config_decode.sv
// Notes on behaviour
// - equalizer pin: low short haul, high long
// - pattern code: normal, ones, random, tx off
// - jitter code 00 off, 01 rx wide 64
// - code 10 rx narrow, 11 tx narrow 128
// - monitor gain pin: low 0dB, high 26dB
// - loopback code: none, analog, digital, remote
// - inband loopback never selectable by pins
// - hiz pin high floats both line drivers
// - edge pin: 0 rising, 1 falling rx clock
`include "strap_params.svh"
`timescale 1ns/100ps
`default_nettype none
module hw_strap_config_decode
   import strap_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic e1_mode,
   input wire chan_pins_s [`NUM_CHAN-1:0] chan_pins,
   input wire logic [1:0] jitter_atten_select,
   input wire logic driver_hiz_select,
   input wire logic rx_clock_edge_select,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output chan_ctrl_s [`NUM_CHAN-1:0] chan_ctrl,
   output glob_ctrl_s glob_ctrl,
   output logic [`NUM_CHAN-1:0] cfg_changed
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   localparam int PW = $bits(chan_pins_s) * `NUM_CHAN;
   localparam int GW = 5;
   logic [PW-1:0] pins_sync;
   logic [GW-1:0] glob_sync;
   chan_pins_s [`NUM_CHAN-1:0] pins_s;

   // no glitch filter: a strap moved in traffic is decoded as is
   // straps are asynchronous to clk, so two flops before decode
   strap_sync #(.W(PW)) u_chan_sync (
      .clk(clk),
      .reset_n(reset_n),
      .din(chan_pins),
      .dout(pins_sync)
   );
   strap_sync #(.W(GW)) u_glob_sync (
      .clk(clk),
      .reset_n(reset_n),
      .din({e1_mode, jitter_atten_select, driver_hiz_select,
            rx_clock_edge_select}),
      .dout(glob_sync)
   );
   assign pins_s = pins_sync;

   // ----------------------------------------
   // decode functions
   // ----------------------------------------
   // one channel's straps to its control settings
   function automatic chan_ctrl_s dec_chan(input chan_pins_s p,
                                           input logic e1);
      chan_ctrl_s c;
      c = '0;
      c.long_haul = p.haul_range_select;
      if (!p.haul_range_select) begin
         c.sens_db = `SENS_SHORT_DB;
      end else if (e1) begin
         c.sens_db = `SENS_E1_DB;
      end else begin
         c.sens_db = `SENS_T1_DB;
      end
      c.rx_powerdown = p.receiver_powerdown_select;
      unique case (p.tx_pattern_select)
         `TXP_NORMAL: c.tx_mode = tx_normal;
         `TXP_ONES: c.tx_mode = tx_all_ones;
         `TXP_RANDOM: c.tx_mode = tx_pseudo_random;
         `TXP_OFF: c.tx_mode = tx_off;
      endcase
      c.tx_powerdown = (p.tx_pattern_select == `TXP_OFF);
      c.mon_gain_db = p.monitor_gain_select ? `GAIN_HIGH_DB
                                           : `GAIN_LOW_DB;
      // only four codes exist, so inband can never be reached
      unique case (p.loopback_select)
         `LOOP_NONE: c.lb_mode = lb_none;
         `LOOP_ANALOG: c.lb_mode = lb_analog;
         `LOOP_DIGITAL: c.lb_mode = lb_digital;
         `LOOP_REMOTE: c.lb_mode = lb_remote;
      endcase
      return c;
   endfunction

   // global straps to attenuator, driver and clock edge settings
   function automatic glob_ctrl_s dec_glob(input logic [1:0] jit,
                                           input logic hiz,
                                           input logic edge_sel);
      glob_ctrl_s g;
      g = '0;
      unique case (jit)
         `JIT_OFF: g.jit_mode = jit_off;
         `JIT_RX_WIDE: g.jit_mode = jit_rx_wide;
         `JIT_RX_NARROW: g.jit_mode = jit_rx_narrow;
         `JIT_TX_NARROW: g.jit_mode = jit_tx_narrow;
      endcase
      g.jit_enable = (jit != `JIT_OFF);
      g.jit_in_tx = (jit == `JIT_TX_NARROW);
      g.jit_narrow = (jit == `JIT_RX_NARROW) ||
                     (jit == `JIT_TX_NARROW);
      // off reports no depth so software sees a plain zero
      if (jit == `JIT_RX_WIDE) begin
         g.jit_fifo_bits = `FIFO_SHORT;
      end else if (jit == `JIT_OFF) begin
         g.jit_fifo_bits = `FIFO_NONE;
      end else begin
         g.jit_fifo_bits = `FIFO_LONG;
      end
      g.driver_hiz = hiz;
      g.rx_falling_edge = edge_sel;
      return g;
   endfunction

   // ----------------------------------------
   // read-back helpers
   // ----------------------------------------
   // decode words sit right-aligned, unused upper bits read zero
   function automatic logic [31:0] chan_word(input chan_ctrl_s c);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[$bits(chan_ctrl_s)-1:0] = c;
      return w;
   endfunction

   function automatic logic [31:0] glob_word(input glob_ctrl_s g);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[$bits(glob_ctrl_s)-1:0] = g;
      return w;
   endfunction

   // ----------------------------------------
   // decoded control registers
   // ----------------------------------------
   // sticky flags keep a change visible until software clears it
   chan_ctrl_s [`NUM_CHAN-1:0] nxt_chan_ctrl;
   glob_ctrl_s nxt_glob_ctrl;
   logic [`NUM_CHAN-1:0] nxt_cfg_changed;
   logic [`NUM_CHAN-1:0] chg_sticky_ff;
   logic [`NUM_CHAN-1:0] nxt_chg_sticky;
   logic [`NUM_CHAN-1:0] chg_clr;
   logic ready_ff;
   logic nxt_ready;

   // a channel decode change is a reconfiguration; flag it per channel (jitter, hiz and edge straps never flag)
   always_comb begin
      nxt_glob_ctrl = dec_glob(glob_sync[3:2], glob_sync[1], glob_sync[0]);
      nxt_ready = 1'b1;
      for (int i = 0; i < `NUM_CHAN; i++) begin
         nxt_chan_ctrl[i] = dec_chan(pins_s[i], glob_sync[4]);
         nxt_cfg_changed[i] = ready_ff &&
                              (nxt_chan_ctrl[i] != chan_ctrl[i]);
         // set wins over a clear in the same cycle
         nxt_chg_sticky[i] = nxt_cfg_changed[i] ||
                             (chg_sticky_ff[i] && !chg_clr[i]);
      end
   end

   // decode and flags only register here
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         chan_ctrl <= '0;
         glob_ctrl <= '0;
         cfg_changed <= '0;
         chg_sticky_ff <= '0;
         ready_ff <= 1'b0;
      end else begin
         chan_ctrl <= nxt_chan_ctrl;
         glob_ctrl <= nxt_glob_ctrl;
         cfg_changed <= nxt_cfg_changed;
         chg_sticky_ff <= nxt_chg_sticky;
         ready_ff <= nxt_ready;
      end
   end

   // ----------------------------------------
   // register port
   // ----------------------------------------
   logic [31:0] nxt_rdata;

   // write-one-to-clear on the status word
   // writes to any other offset are dropped on purpose
   always_comb begin
      chg_clr = '0;
      if (reg_wr && reg_addr == `REG_OFS_STATUS) begin
         chg_clr = reg_wdata[`NUM_CHAN-1:0];
      end
   end

   // read data stand one cycle only, then zero
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (reg_rd) begin
         unique case (reg_addr)
            `REG_OFS_STATUS: nxt_rdata = {30'h0, chg_sticky_ff};
            `REG_OFS_CH0: nxt_rdata = chan_word(chan_ctrl[0]);
            `REG_OFS_CH1: nxt_rdata = chan_word(chan_ctrl[1]);
            `REG_OFS_GLOBAL: nxt_rdata = glob_word(glob_ctrl);
            default: nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   // read data register, zero whenever no read was made
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= nxt_rdata;
      end
   end
endmodule
`default_nettype wire

// ### rtl/strap_params.svh
`ifndef STRAP_PARAMS_SVH
`define STRAP_PARAMS_SVH
`define NUM_CHAN 2
`define TXP_NORMAL 2'h0
`define TXP_ONES 2'h1
`define TXP_RANDOM 2'h2
`define TXP_OFF 2'h3
`define JIT_OFF 2'h0
`define JIT_RX_WIDE 2'h1
`define JIT_RX_NARROW 2'h2
`define JIT_TX_NARROW 2'h3
`define LOOP_NONE 2'h0
`define LOOP_ANALOG 2'h1
`define LOOP_DIGITAL 2'h2
`define LOOP_REMOTE 2'h3
`define FIFO_NONE 8'h00
`define FIFO_SHORT 8'h40
`define FIFO_LONG 8'h80
`define SENS_SHORT_DB 6'h0A
`define SENS_T1_DB 6'h24
`define SENS_E1_DB 6'h2B
`define GAIN_LOW_DB 5'h00
`define GAIN_HIGH_DB 5'h1A
`define REG_OFS_STATUS 4'h0
`define REG_OFS_CH0 4'h1
`define REG_OFS_CH1 4'h2
`define REG_OFS_GLOBAL 4'h3
`endif

// ### rtl/strap_pkg.sv
`default_nettype none
package strap_pkg;
   typedef enum logic [1:0] {
      tx_normal, tx_all_ones, tx_pseudo_random, tx_off
   } tx_mode_e;
   typedef enum logic [1:0] {
      lb_none, lb_analog, lb_digital, lb_remote
   } lb_mode_e;
   typedef enum logic [1:0] {
      jit_off, jit_rx_wide, jit_rx_narrow, jit_tx_narrow
   } jit_mode_e;
   // raw strap levels of one channel
   typedef struct packed {
      logic haul_range_select;
      logic receiver_powerdown_select;
      logic [1:0] tx_pattern_select;
      logic monitor_gain_select;
      logic [1:0] loopback_select;
   } chan_pins_s;
   // decoded controls of one channel
   typedef struct packed {
      logic long_haul;
      logic [5:0] sens_db;
      logic rx_powerdown;
      tx_mode_e tx_mode;
      logic tx_powerdown;
      logic [4:0] mon_gain_db;
      lb_mode_e lb_mode;
   } chan_ctrl_s;
   // decoded global controls
   typedef struct packed {
      jit_mode_e jit_mode;
      logic jit_enable;
      logic jit_in_tx;
      logic jit_narrow;
      logic [7:0] jit_fifo_bits;
      logic driver_hiz;
      logic rx_falling_edge;
   } glob_ctrl_s;
endpackage
`default_nettype wire

// ### rtl/strap_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two-stage synchroniser for a bus of strap levels
module strap_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] nxt_meta;
   logic [W-1:0] nxt_dout;

   // first stage read only by the second
   always_comb begin
      nxt_meta = din;
      nxt_dout = meta_ff;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_ff <= '0;
         dout <= '0;
      end else begin
         meta_ff <= nxt_meta;
         dout <= nxt_dout;
      end
   end
endmodule
`default_nettype wire

// ### verif/hw_strap_config_decode_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "strap_params.svh"
module hw_strap_config_decode_test
   import strap_pkg::*;
;
   typedef struct packed {
      logic [6:0] pins;
      logic [1:0] jit;
      logic hiz;
      logic edg;
      logic e1;
      logic [5:0] sens;
      logic [7:0] fifo;
      logic [4:0] gain;
   } row_s;
   // pins: haul, rx pd, pattern, gain, loopback; every code once
   row_s rows [4] = '{
      '{7'h00, 2'h0, 1'h0, 1'h0, 1'h0, 6'h0A, 8'h00, 5'h00},
      '{7'h6D, 2'h1, 1'h1, 1'h1, 1'h0, 6'h24, 8'h40, 5'h1A},
      '{7'h52, 2'h2, 1'h0, 1'h1, 1'h1, 6'h2B, 8'h80, 5'h00},
      '{7'h3F, 2'h3, 1'h1, 1'h0, 1'h1, 6'h0A, 8'h80, 5'h1A}};
   logic clk, reset_n, load, reg_wr, reg_rd;
   chan_pins_s new_pins;
   logic [4:0] new_glob;
   logic [4:0] glob;
   chan_pins_s [1:0] chan_pins;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   chan_ctrl_s [1:0] chan_ctrl;
   glob_ctrl_s glob_ctrl;
   logic [1:0] cfg_changed;
   int n_mismatch = 0;
   int comparisons = 0;
   strap_board strap_board_i (.clk(clk), .load(load), .new_pins(new_pins),
      .new_glob(new_glob), .chan_pins(chan_pins), .glob(glob));
   hw_strap_config_decode hw_strap_config_decode_i (.clk(clk),
      .reset_n(reset_n), .e1_mode(glob[0]), .chan_pins(chan_pins),
      .jitter_atten_select(glob[4:3]), .driver_hiz_select(glob[2]),
      .rx_clock_edge_select(glob[1]), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .chan_ctrl(chan_ctrl), .glob_ctrl(glob_ctrl),
      .cfg_changed(cfg_changed));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // -----------------------------
   // shared tasks
   // -----------------------------
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(logic [3:0] a, logic [31:0] exp, string what);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(what, exp, reg_rdata);
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      reset_n = 1'b0;
      load = 1'b0;
      new_pins = '0;
      new_glob = 5'h00;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (4) @(posedge clk);
      chk("reset ctrl0", 32'h0, chan_ctrl[0]);
      chk("reset ctrl1", 32'h0, chan_ctrl[1]);
      reset_n <= 1'b1;
      // three edges of decode latency plus one for the board model
      foreach (rows[i]) begin
         @(posedge clk);
         load <= 1'b1;
         new_pins <= rows[i].pins;
         new_glob <= {rows[i].jit, rows[i].hiz, rows[i].edg, rows[i].e1};
         @(posedge clk);
         load <= 1'b0;
         repeat (3) @(posedge clk);
         // the change flag stands only in the cycle the decode moves
         #1 chk("chg_pulse", (i == 0) ? 32'h0 : 32'h3, cfg_changed);
         @(posedge clk);
         #1 chk("chg_idle", 32'h0, cfg_changed);
         chk("long_haul", rows[i].pins[6], chan_ctrl[0].long_haul);
         chk("sens_db", rows[i].sens, chan_ctrl[0].sens_db);
         chk("rx_pd", rows[i].pins[5], chan_ctrl[0].rx_powerdown);
         chk("tx_mode", rows[i].pins[4:3], chan_ctrl[1].tx_mode);
         chk("tx_pd", &rows[i].pins[4:3], chan_ctrl[1].tx_powerdown);
         chk("fifo", rows[i].fifo, glob_ctrl.jit_fifo_bits);
         chk("jit_on", rows[i].jit != 2'h0, glob_ctrl.jit_enable);
         chk("jit_tx", rows[i].jit == 2'h3, glob_ctrl.jit_in_tx);
         chk("jit_narrow", rows[i].jit[1], glob_ctrl.jit_narrow);
         chk("gain", rows[i].gain, chan_ctrl[0].mon_gain_db);
         chk("loop", rows[i].pins[1:0], chan_ctrl[0].lb_mode);
         chk("hiz", rows[i].hiz, glob_ctrl.driver_hiz);
         chk("edge", rows[i].edg, glob_ctrl.rx_falling_edge);
         $display("row %0d done", i);
      end
      // sticky change flags, write-one-to-clear, unmapped place
      rd(4'h0, 32'h3, "status set");
      wr(4'h0, 32'h3);
      rd(4'h0, 32'h0, "status cleared");
      rd(4'hF, 32'h0, "unmapped");
      @(posedge clk);
      reset_n <= 1'b0;
      @(posedge clk);
      #1 chk("mid reset glob", 32'h0, glob_ctrl);
      @(posedge clk);
      reset_n <= 1'b1;
      // two edges on, the decode still shows the synchroniser's reset zeros
      repeat (2) @(posedge clk);
      #1 chk("fifo after reset", `FIFO_NONE, glob_ctrl.jit_fifo_bits);
      repeat (2) @(posedge clk);
      #1 chk("fifo resync", `FIFO_LONG, glob_ctrl.jit_fifo_bits);
      $display("hand tests done");
      stop_test();
   end
endmodule
`default_nettype wire

// ### verif/strap_board.sv
`timescale 1ns/100ps
`default_nettype none
// -----------------------------
// board strapping model
// -----------------------------
// levels move only on load, so every change is a deliberate reconfig
module strap_board
   import strap_pkg::*;
(
   input wire logic clk,
   input wire logic load,
   input wire chan_pins_s new_pins,
   input wire logic [4:0] new_glob,
   output var chan_pins_s [1:0] chan_pins,
   output logic [4:0] glob
);
   // both channels strapped alike to keep the stimulus small
   initial begin
      chan_pins = '0;
      glob = 5'h00;
      forever begin
         @(posedge clk);
         if (load) begin
            chan_pins <= {new_pins, new_pins};
            glob <= new_glob;
         end
      end
   end
endmodule
`default_nettype wire

// ### verif/strap_decode_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "strap_params.svh"
module strap_decode_checker
   import strap_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic e1_mode,
   input wire chan_pins_s [`NUM_CHAN-1:0] chan_pins,
   input wire logic [1:0] jitter_atten_select,
   input wire logic driver_hiz_select,
   input wire logic rx_clock_edge_select,
   input wire chan_ctrl_s [`NUM_CHAN-1:0] chan_ctrl,
   input wire glob_ctrl_s glob_ctrl,
   input wire logic [`NUM_CHAN-1:0] cfg_changed
);
   logic [2:0] up_ff;
   logic [2:0] nxt_up;
   logic settled;
   // settle count: $past must not reach back into reset
   always_comb nxt_up = (up_ff == 3'h4) ? up_ff : up_ff + 3'h1;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) up_ff <= 3'h0;
      else up_ff <= nxt_up;
   end
   assign settled = (up_ff == 3'h4);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // -----------------------------
   // decode follows straps, three edges late
   // -----------------------------
   a_haul_range: assert property (settled |->
      chan_ctrl[0].sens_db == (!$past(chan_pins[0].haul_range_select, 3) ?
      `SENS_SHORT_DB : $past(e1_mode, 3) ? `SENS_E1_DB : `SENS_T1_DB))
      else $error("haul range sensitivity wrong");
   a_tx_pattern: assert property (settled |->
      chan_ctrl[1].tx_mode == $past(chan_pins[1].tx_pattern_select, 3) &&
      chan_ctrl[1].tx_powerdown == ($past(chan_pins[1].tx_pattern_select, 3)
      == `TXP_OFF)) else $error("tx pattern decode wrong");
   a_jit_fifo: assert property (settled |-> glob_ctrl.jit_fifo_bits ==
      ($past(jitter_atten_select, 3) == `JIT_OFF ? `FIFO_NONE :
      $past(jitter_atten_select, 3) == `JIT_RX_WIDE ? `FIFO_SHORT :
      `FIFO_LONG)) else $error("jitter fifo depth wrong");
   a_jit_place: assert property (settled |->
      glob_ctrl.jit_in_tx == ($past(jitter_atten_select, 3) == `JIT_TX_NARROW)
      && glob_ctrl.jit_narrow == $past(jitter_atten_select[1], 3))
      else $error("jitter placement wrong");
   a_mon_gain: assert property (settled |-> chan_ctrl[0].mon_gain_db ==
      ($past(chan_pins[0].monitor_gain_select, 3) ? `GAIN_HIGH_DB :
      `GAIN_LOW_DB)) else $error("monitor gain wrong");
   a_loop_mode: assert property (settled |->
      chan_ctrl[0].lb_mode == $past(chan_pins[0].loopback_select, 3))
      else $error("loopback decode wrong");
   a_driver_hiz: assert property (settled |->
      glob_ctrl.driver_hiz == $past(driver_hiz_select, 3))
      else $error("driver hiz wrong");
   a_rx_edge: assert property (settled |->
      glob_ctrl.rx_falling_edge == $past(rx_clock_edge_select, 3))
      else $error("rx clock edge wrong");
   a_change_flag: assert property (settled |->
      cfg_changed[0] == (chan_ctrl[0] != $past(chan_ctrl[0])))
      else $error("change flag wrong");
   cover property (cfg_changed[0]);
   cover property (glob_ctrl.jit_in_tx);
   cover property (chan_ctrl[1].tx_powerdown);
endmodule
bind hw_strap_config_decode strap_decode_checker strap_decode_checker_i (
   .clk(clk), .reset_n(reset_n), .e1_mode(e1_mode), .chan_pins(chan_pins),
   .jitter_atten_select(jitter_atten_select),
   .driver_hiz_select(driver_hiz_select),
   .rx_clock_edge_select(rx_clock_edge_select), .chan_ctrl(chan_ctrl),
   .glob_ctrl(glob_ctrl), .cfg_changed(cfg_changed));
`default_nettype wire
